// ---- hw/pxc_phy_regs.sv ----
// management register bank of the phy: strap status, expanded control, interrupt
// control/status, a management serial slave and the mii receive preamble/latency stage
// assumes CLK_SYS is at least eight times the management clock and that event strobes
// and the receive nibble stream come from logic on CLK_SYS
`timescale 1ns/1ps

`include "pxc_map.svh"

// Operation
// - strap status bit 0 shows mii strap
// - strap status bit 1 shows rmii strap
// - control bit 11 disables energy-detect powerdown
// - control bit 10 selects random 100 latency
// - all 100 preamble bytes reach mii output
// - control bit 6 keeps 10 preamble
// - otherwise strip preamble, start at sfd
// - interrupt bits 15..8 are rw enables
// - bit 7 jabber flag, clear on read
// - bit 6 receive error flag, clear on read
// - bit 5 page received flag, clear on read
// - bit 4 parallel detect fault flag
// - bit 3 link partner acknowledge flag
// - bit 2 link down flag
// - bit 1 remote fault flag
// - bit 0 link up flag
module pxc_phy_regs
    import pxc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR       = 5'h00,
    parameter int         FIX_LAT_STAGES = 2
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_B,
    input  wire logic       MDC,
    input  wire logic       MDIO_I,
    output logic            MDIO_O,
    output logic            MDIO_OE,
    input  wire logic       STRAP_MII,
    input  wire logic       STRAP_RMII,
    input  wire pxc_event_s EVENTS,
    input  wire logic       SPEED_10,
    input  wire pxc_rx_s    RX_IN,
    output pxc_rx_s         MII_RX,
    output logic            ENERGY_DETECT_POWERDOWN_EN,
    output logic            IRQ_B
);

    // the fixed-latency delay line must hold at least one and at most eight nibbles
    if (FIX_LAT_STAGES < 1 || FIX_LAT_STAGES > 8) begin : g_bad_lat
        $error("FIX_LAT_STAGES out of range");
    end

    logic [1:0]  mdc_sync_ff;
    logic [1:0]  mdio_sync_ff;
    logic [1:0]  strap_mii_sync_ff;
    logic [1:0]  strap_rmii_sync_ff;
    logic        mdc_prev_ff;
    logic        mdc_rise;
    pxc_mdio_e   state_ff;
    logic [3:0]  cnt_ff;
    logic [11:0] hdr_ff;
    logic        rd_ff;
    logic        hit_ff;
    logic [15:0] sh_ff;
    logic        wr_stb;
    logic        rd_stb;
    logic [4:0]  hdr_reg;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic [1:0]  settle_ff;
    logic [1:0]  strap_ff;
    logic [15:0] exp_ctrl_ff;
    logic [7:0]  irq_en_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  nxt_flags;
    logic        strip;
    logic        fixed_lat;
    logic        sfd_now;
    logic        start_now;
    pxc_rx_s     prev_ff;
    logic        hunt_ff;
    pxc_rx_s     gated;
    pxc_rx_s     lat_ff [FIX_LAT_STAGES];

    // register read mux; unmapped offsets and bits outside this bank read zero
    function automatic logic [15:0] read_reg(input logic [4:0] ofs, input logic [1:0] straps,
                                             input logic [15:0] ctrl, input logic [7:0] en,
                                             input logic [7:0] flg);
        logic [15:0] v;
        v = 16'h0000;
        unique case (ofs)
            `PXC_OFS_STRAP_STATUS:  v = {14'h0000, straps};
            `PXC_OFS_EXP_CTRL:      v = ctrl;
            `PXC_OFS_IRQ_CTRL_STAT: v = {en, flg};
            default:                v = 16'h0000;
        endcase
        return v;
    endfunction

    // pin inputs pass two flops before any logic looks at them
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mdc_sync_ff        <= 2'h0;
            mdio_sync_ff       <= 2'h3;
            strap_mii_sync_ff  <= 2'h0;
            strap_rmii_sync_ff <= 2'h0;
        end else begin
            mdc_sync_ff        <= {mdc_sync_ff[0], MDC};
            mdio_sync_ff       <= {mdio_sync_ff[0], MDIO_I};
            strap_mii_sync_ff  <= {strap_mii_sync_ff[0], STRAP_MII};
            strap_rmii_sync_ff <= {strap_rmii_sync_ff[0], STRAP_RMII};
        end
    end

    // management clock edge detect on the synced copy only
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mdc_prev_ff <= 1'b0;
        end else begin
            mdc_prev_ff <= mdc_sync_ff[1];
        end
    end

    assign mdc_rise = mdc_sync_ff[1] & ~mdc_prev_ff;
    assign hdr_reg  = hdr_ff[4:0];
    assign wr_data  = {sh_ff[14:0], mdio_sync_ff[1]};
    // a request is ours only with the right address; others are walked but never answered
    assign rd_stb   = mdc_rise && state_ff == PXC_TA && cnt_ff == 4'h1 && hit_ff && rd_ff;
    assign wr_stb   = mdc_rise && state_ff == PXC_DATA && cnt_ff == `PXC_MDIO_DATA_LAST && hit_ff && !rd_ff;
    assign rd_data  = read_reg(hdr_reg, strap_ff, exp_ctrl_ff, irq_en_ff, flags_ff);

    // frame walker: ones as preamble, 01 start, op, phy address, register, turnaround, data
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= PXC_IDLE;
            cnt_ff   <= 4'h0;
            hdr_ff   <= 12'h000;
            rd_ff    <= 1'b0;
            hit_ff   <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_ff)
                PXC_IDLE: begin
                    if (!mdio_sync_ff[1]) begin
                        state_ff <= PXC_START;
                    end
                end
                PXC_START: begin
                    state_ff <= mdio_sync_ff[1] ? PXC_HDR : PXC_IDLE;
                    cnt_ff   <= 4'h0;
                end
                PXC_HDR: begin
                    hdr_ff <= {hdr_ff[10:0], mdio_sync_ff[1]};
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == `PXC_MDIO_HDR_BITS - 4'h1) begin
                        state_ff <= PXC_TA;
                        cnt_ff   <= 4'h0;
                        rd_ff    <= hdr_ff[10:9] == `PXC_MDIO_OP_READ;
                        hit_ff   <= hdr_ff[8:4] == PHY_ADDR
                                    && (hdr_ff[10:9] == `PXC_MDIO_OP_READ
                                        || hdr_ff[10:9] == `PXC_MDIO_OP_WRITE);
                    end
                end
                PXC_TA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == 4'h1) begin
                        state_ff <= PXC_DATA;
                        cnt_ff   <= 4'h0;
                    end
                end
                PXC_DATA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == `PXC_MDIO_DATA_LAST) begin
                        state_ff <= PXC_IDLE;
                        cnt_ff   <= 4'h0;
                    end
                end
            endcase
        end
    end

    // data shifter and serial data drive; read data is loaded when the turnaround ends
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            sh_ff   <= 16'h0000;
            MDIO_O  <= 1'b1;
            MDIO_OE <= 1'b0;
        end else if (mdc_rise) begin
            if (state_ff == PXC_TA && cnt_ff == 4'h0) begin
                MDIO_O  <= 1'b0;
                MDIO_OE <= hit_ff && rd_ff;
            end else if (state_ff == PXC_TA) begin
                sh_ff   <= rd_data;
                MDIO_O  <= rd_data[15];
            end else if (state_ff == PXC_DATA) begin
                sh_ff  <= wr_data;
                MDIO_O <= sh_ff[14];
                if (cnt_ff == `PXC_MDIO_DATA_LAST) begin
                    MDIO_OE <= 1'b0;
                    MDIO_O  <= 1'b1;
                end
            end
        end
    end

    // straps are caught once the synchronisers hold post-reset pin levels
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            settle_ff <= 2'h0;
            strap_ff  <= 2'h0;
        end else if (settle_ff != `PXC_STRAP_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == `PXC_STRAP_SETTLE - 2'h1) begin
                strap_ff[`PXC_STRAP_MII_BIT]  <= strap_mii_sync_ff[1];
                strap_ff[`PXC_STRAP_RMII_BIT] <= strap_rmii_sync_ff[1];
            end
        end
    end

    // expanded control register; reserved bits are plain storage
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            exp_ctrl_ff <= `PXC_EXP_CTRL_RST;
        end else if (wr_stb && hdr_reg == `PXC_OFS_EXP_CTRL) begin
            exp_ctrl_ff <= wr_data;
        end
    end

    // interrupt enables; the low byte of a write is ignored since flags are read only
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            irq_en_ff <= 8'(`PXC_IRQ_CTRL_RST >> `PXC_IRQ_EN_LSB);
        end else if (wr_stb && hdr_reg == `PXC_OFS_IRQ_CTRL_STAT) begin
            irq_en_ff <= wr_data[15:`PXC_IRQ_EN_LSB];
        end
    end

    // flags clear on the read that reports them; an event in that very cycle survives
    always_comb begin
        nxt_flags = flags_ff;
        if (rd_stb && hdr_reg == `PXC_OFS_IRQ_CTRL_STAT) begin
            nxt_flags = 8'h00;
        end
        nxt_flags = nxt_flags | EVENTS;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            flags_ff <= 8'h00;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // interrupt and power-down outputs come from their own flops
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_B                      <= 1'b1;
            ENERGY_DETECT_POWERDOWN_EN <= 1'b0;
        end else begin
            IRQ_B                      <= ~|(nxt_flags & irq_en_ff);
            ENERGY_DETECT_POWERDOWN_EN <= ~exp_ctrl_ff[`PXC_EXP_ENERGY_DETECT_POWERDOWN_DIS_BIT];
        end
    end

    // 10 mode without restore hides preamble; 100 mode never drops a nibble
    assign strip     = SPEED_10 && !exp_ctrl_ff[`PXC_EXP_PRE_RESTORE_BIT];
    assign fixed_lat = !SPEED_10 && !exp_ctrl_ff[`PXC_EXP_RAND_LAT_BIT];
    assign sfd_now   = RX_IN.dv && RX_IN.data == `PXC_SFD_HI_NIBBLE;
    assign start_now = RX_IN.dv && !prev_ff.dv;

    // one nibble of look-ahead so the low sfd nibble is released when its high half shows
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            prev_ff <= '0;
            hunt_ff <= 1'b0;
        end else begin
            prev_ff <= RX_IN;
            hunt_ff <= strip && RX_IN.dv && !sfd_now && (start_now || hunt_ff);
        end
    end

    always_comb begin
        gated    = prev_ff;
        gated.dv = prev_ff.dv && !(hunt_ff && !sfd_now);
    end

    // fixed latency adds a constant delay line; random latency takes the short path
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < FIX_LAT_STAGES; i++) begin
                lat_ff[i] <= '0;
            end
        end else begin
            lat_ff[0] <= gated;
            for (int i = 1; i < FIX_LAT_STAGES; i++) begin
                lat_ff[i] <= lat_ff[i-1];
            end
        end
    end

    // a latency change mid-frame can tear that frame; software changes it between frames
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            MII_RX <= '0;
        end else begin
            MII_RX <= fixed_lat ? lat_ff[FIX_LAT_STAGES-1] : gated;
        end
    end

endmodule

// ---- inc/pxc_map.svh ----
// register map, field positions, reset values and frame constants of the phy control bank
// assumes inclusion from the package and the design file by bare name
`ifndef PXC_MAP_SVH
`define PXC_MAP_SVH

// register offsets on the management serial bus
`define PXC_OFS_STRAP_STATUS   5'h17
`define PXC_OFS_EXP_CTRL       5'h18
`define PXC_OFS_IRQ_CTRL_STAT  5'h1b

// strap status fields
`define PXC_STRAP_MII_BIT      0
`define PXC_STRAP_RMII_BIT     1

// expanded control fields and reset value
`define PXC_EXP_ENERGY_DETECT_POWERDOWN_DIS_BIT   11
`define PXC_EXP_RAND_LAT_BIT   10
`define PXC_EXP_PRE_RESTORE_BIT 6
`define PXC_EXP_CTRL_RST       16'h0800

// interrupt control/status: enables sit eight above their flags
`define PXC_IRQ_EN_LSB         8
`define PXC_IRQ_CTRL_RST       16'h0000

// management frame: opcodes, field lengths
`define PXC_MDIO_OP_WRITE      2'h1
`define PXC_MDIO_OP_READ       2'h2
`define PXC_MDIO_HDR_BITS      4'hc
`define PXC_MDIO_DATA_LAST     4'hf

// strap capture: edges after reset release before the synced straps are valid
`define PXC_STRAP_SETTLE       2'h3

// start-of-frame delimiter high nibble on the receive nibble stream
`define PXC_SFD_HI_NIBBLE      4'hd

`endif

// ---- inc/pxc_pkg.sv ----
// types shared by the phy control bank
// assumes pxc_map.svh is on the include path
package pxc_pkg;
    `include "pxc_map.svh"

    // management frame walker
    typedef enum logic [2:0] {
        PXC_IDLE,
        PXC_START,
        PXC_HDR,
        PXC_TA,
        PXC_DATA
    } pxc_mdio_e;

    // one-cycle event strobes from the core, msb first in flag order
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pxc_event_s;

    // receive nibble stream toward the mii output
    typedef struct packed {
        logic       dv;
        logic [3:0] data;
    } pxc_rx_s;
endpackage

// ---- test/pxc_phy_regs_checker.sv ----
// checker: port timing relations of the phy control bank
// assumes it is bound into pxc_phy_regs and sees one clock domain
`timescale 1ns/1ps
module pxc_phy_regs_checker
    import pxc_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST_B,
    input wire logic       MDC,
    input wire logic       MDIO_O,
    input wire logic       MDIO_OE,
    input wire pxc_event_s EVENTS,
    input wire logic       SPEED_10,
    input wire pxc_rx_s    RX_IN,
    input wire pxc_rx_s    MII_RX,
    input wire logic       ENERGY_DETECT_POWERDOWN_EN,
    input wire logic       IRQ_B
);
    logic       mdc_ff;
    logic [7:0] since_ff;
    logic [3:0] idle_ff;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    // cycles since the last mdc rise; saturates so a long idle cannot wrap into a pass
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mdc_ff   <= 1'b0;
            since_ff <= 8'hff;
        end else begin
            mdc_ff   <= MDC;
            since_ff <= (MDC && !mdc_ff) ? 8'h00 : since_ff + {7'h00, since_ff != 8'hff};
        end
    end

    // idle cycles on the receive input, saturating
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) idle_ff <= 4'h0;
        else idle_ff <= RX_IN.dv ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hf};
    end

    a_irq_rise_cause: assert property ($rose(IRQ_B) |-> since_ff < 8'h0a)
        else $error("interrupt released without a management access");
    a_irq_fall_cause: assert property ($fell(IRQ_B) |-> $past(EVENTS) != 8'h00 || since_ff < 8'h0a)
        else $error("interrupt raised without an event or enable write");
    a_oe_needs_mdc: assert property (MDIO_OE |-> since_ff < 8'h28)
        else $error("management data driven with the bus idle");
    a_ta_low: assert property ($rose(MDIO_OE) |-> !MDIO_O)
        else $error("turnaround bit not low");
    a_oe_after_rise: assert property ($rose(MDIO_OE) |-> since_ff inside {[8'h01:8'h07]})
        else $error("data drive not started just after a clock rise");
    a_o_steady: assert property (MDIO_OE && $past(MDIO_OE) && $changed(MDIO_O) |-> since_ff < 8'h08)
        else $error("read data changed between clock rises");
    a_energy_detect_powerdown_cause: assert property ($changed(ENERGY_DETECT_POWERDOWN_EN) |-> since_ff < 8'h0a)
        else $error("power-down enable changed without a write");
    a_mii_follow: assert property (RX_IN.dv && !SPEED_10 |-> ##[1:12] MII_RX.dv)
        else $error("fast receive nibble dropped");
    a_mii_idle: assert property (idle_ff >= 4'hc |-> !MII_RX.dv)
        else $error("receive output valid with no input");
endmodule

// ---- test/pxc_mdio_host.sv ----
// host model: management frames toward the phy control bank
// assumes the data line has a pull-up, so a released line reads one
`timescale 1ns/1ps
`include "pxc_map.svh"
module pxc_mdio_host #(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int         HALF     = 8
) (
    input  wire logic clk_sys,
    output logic      mdc,
    output logic      mdio_i,
    input  wire logic mdio_o,
    input  wire logic mdio_oe
);
    logic host_oe  = 1'b0;
    logic host_bit = 1'b1;

    // wire level: host, then device, else the pull-up
    always_comb begin
        if (host_oe) mdio_i = host_bit;
        else if (mdio_oe) mdio_i = mdio_o;
        else mdio_i = 1'b1;
    end

    initial mdc = 1'b0;

    // one clock period; HALF must keep mdc at or below an eighth of the core clock
    task automatic bit_cycle(input logic drv, input logic val, output logic smp);
        host_oe = drv;
        host_bit = val;
        repeat (HALF) @(posedge clk_sys);
        smp = mdio_i;
        #1 mdc = 1'b1;
        repeat (HALF) @(posedge clk_sys);
        #1 mdc = 1'b0;
    endtask

    // preamble, header, turnaround, 16 data bits msb first, then one idle bit to close
    task automatic xfer(input logic rd, input logic [4:0] ofs, input logic [15:0] wdata, output logic [15:0] rdata);
        logic [19:0] hdr;
        logic        s;
        hdr = {4'hf, 2'h1, rd ? `PXC_MDIO_OP_READ : `PXC_MDIO_OP_WRITE, PHY_ADDR, ofs, 2'h2};
        for (int i = 19; i >= 0; i--) bit_cycle(!rd || i > 1, hdr[i], s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(!rd, wdata[i], s);
            rdata[i] = s;
        end
        bit_cycle(1'b0, 1'b1, s);
    endtask
endmodule

// ---- test/phy_irq_and_expanded_control_tb_top.sv ----
// testbench: registers, events and receive stream of the phy control bank against a bench model
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
`include "pxc_map.svh"
module phy_irq_and_expanded_control_tb_top;
    import pxc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b   = 1'b0;
    logic        mdc, mdio_i, mdio_o, mdio_oe, energy_detect_powerdown_en, irq_b, strap_mii, strap_rmii;
    logic        speed_10 = 1'b0;
    pxc_event_s  events   = '0;
    pxc_rx_s     rx_in    = '0;
    pxc_rx_s     mii_rx;
    logic [31:0] seed = 32'h0000000a;
    logic [31:0] v;
    logic [15:0] d;
    logic [7:0]  en, flg;
    logic [3:0]  got[$], exp[$];
    int          mismatches = 0;
    int          num_checks = 0;

    always #20 clk_sys = ~clk_sys;

    pxc_phy_regs #(.PHY_ADDR(5'h00), .FIX_LAT_STAGES(2)) dut_u (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .MDC(mdc), .MDIO_I(mdio_i), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe),
        .STRAP_MII(strap_mii), .STRAP_RMII(strap_rmii), .EVENTS(events), .SPEED_10(speed_10), .RX_IN(rx_in),
        .MII_RX(mii_rx), .ENERGY_DETECT_POWERDOWN_EN(energy_detect_powerdown_en), .IRQ_B(irq_b));

    pxc_mdio_host #(.PHY_ADDR(5'h00), .HALF(8)) host_u (
        .clk_sys(clk_sys), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

    // collect every valid nibble leaving the mii side
    always @(posedge clk_sys) if (mii_rx.dv === 1'b1) got.push_back(mii_rx.data);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_reg({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
        chk_reg({12'h000, g}, {12'h000, e});
    endtask

    task automatic rd(input logic [4:0] ofs, input logic [15:0] e);
        host_u.xfer(1'b1, ofs, 16'h0000, d);
        chk_reg(d, e);
    endtask

    task automatic wr(input logic [4:0] ofs, input logic [15:0] w);
        host_u.xfer(1'b0, ofs, w, d);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // about 40 frames of 37 bits at 16 cycles each, with ample margin
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        wrap_up();
    end

    initial begin
        v = rnd();
        strap_mii = v[0];
        strap_rmii = v[1];
        flg = 8'h00;
        repeat (5) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        rd(`PXC_OFS_STRAP_STATUS, {14'h0000, strap_rmii, strap_mii});
        rd(`PXC_OFS_EXP_CTRL, `PXC_EXP_CTRL_RST);
        chk_bit(energy_detect_powerdown_en, 1'b0);
        rd(`PXC_OFS_IRQ_CTRL_STAT, `PXC_IRQ_CTRL_RST);
        wr(`PXC_OFS_STRAP_STATUS, 16'hffff);
        rd(`PXC_OFS_STRAP_STATUS, {14'h0000, strap_rmii, strap_mii});
        rd(5'h05, 16'h0000);
        repeat (3) begin
            v = rnd();
            wr(`PXC_OFS_EXP_CTRL, v[15:0]);
            rd(`PXC_OFS_EXP_CTRL, v[15:0]);
            chk_bit(energy_detect_powerdown_en, !v[11]);
        end
        // one event per flag; odd flags enabled so gating is seen both ways, low byte writes ignored
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            v[8 + i] = i[0];
            en = v[15:8];
            wr(`PXC_OFS_IRQ_CTRL_STAT, v[15:0]);
            events = 8'h01 << i;
            @(posedge clk_sys);
            #1 events = '0;
            flg[i] = 1'b1;
            repeat (2) @(posedge clk_sys);
            #1 chk_bit(irq_b, !(|(en & flg)));
            rd(`PXC_OFS_IRQ_CTRL_STAT, {en, flg});
            flg = 8'h00;
            rd(`PXC_OFS_IRQ_CTRL_STAT, {en, flg});
            chk_bit(irq_b, 1'b1);
        end
        // one frame in each speed and preamble mode: fixed, random, strip, restore
        for (int m = 0; m < 4; m++) begin
            wr(`PXC_OFS_EXP_CTRL, m[0] ? 16'h0440 : 16'h0000);
            speed_10 = m[1];
            got.delete();
            exp.delete();
            for (int k = 0; k < 24; k++) begin
                v = rnd();
                if (k < 16) v[3:0] = (k == 15) ? 4'hd : 4'h5;
                rx_in = '{dv: 1'b1, data: v[3:0]};
                if (m != 2 || k >= 14) exp.push_back(v[3:0]);
                @(posedge clk_sys);
                #1;
            end
            rx_in = '0;
            repeat (20) @(posedge clk_sys);
            #1 chk_reg(16'(got.size()), 16'(exp.size()));
            foreach (exp[k]) chk_nib(got.size() > k ? got[k] : 4'hx, exp[k]);
        end
        wrap_up();
    end
endmodule

bind pxc_phy_regs pxc_phy_regs_checker chk_u (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .MDC(MDC), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .EVENTS(EVENTS),
    .SPEED_10(SPEED_10), .RX_IN(RX_IN), .MII_RX(MII_RX),
    .ENERGY_DETECT_POWERDOWN_EN(ENERGY_DETECT_POWERDOWN_EN), .IRQ_B(IRQ_B));
